//--- src/spc_regs.svh
// Constants of the solenoid pulse controller: offsets, field positions,
// reset values and timing counts.
// Assumes a 200 MHz system clock and a word-indexed register port.
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SPC_CLK_HZ 200000000
`define SPC_MS_CYCLES (`SPC_CLK_HZ / 1000)
`define SPC_MIN_PULSE_MS 75
`define SPC_REPORT_MS 100
`define SPC_AVG_SHIFT 7
`define SPC_SAMPLE_CYCLES (`SPC_CLK_HZ / 1000 * `SPC_REPORT_MS / (1 << `SPC_AVG_SHIFT))
`define SPC_DIV_STEPS 28

// ----------------------------------------
// Register offsets (word index)
// ----------------------------------------
`define SPC_OFS_CTRL 8'h00
`define SPC_OFS_STATUS 8'h01
`define SPC_OFS_PERIOD 8'h02
`define SPC_OFS_TOL 8'h03
`define SPC_OFS_KP 8'h04
`define SPC_OFS_KD 8'h05
`define SPC_OFS_DESIRED 8'h06
`define SPC_OFS_PULSE 8'h07
`define SPC_OFS_LOAD0 8'h08
`define SPC_OFS_CURVE0 8'h20
`define SPC_CURVE_WORDS 24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPC_CTRL_EN_BIT 0
`define SPC_ST_RUN_BIT 0
`define SPC_ST_CONT_BIT 1
`define SPC_ST_RAISE_BIT 2
`define SPC_ST_LOWER_BIT 3
`define SPC_ST_BAND_BIT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPC_RST_PERIOD 16'h01F4
`define SPC_RST_TOL 16'h0008
`define SPC_RST_KP 16'h0004
`define SPC_RST_KD 16'h0002
`define SPC_RST_DESIRED 16'h0800

`endif

//--- src/spc_pkg.sv
// Types shared by the solenoid pulse controller and its load converter.
// Assumes the constants header is included where numbers are needed.
package spc_pkg;

  typedef logic [11:0] press_t;
  typedef logic [11:0] level_t;
  typedef logic [15:0] load_t;

  // One calibration point: axle weight at a bellows pressure
  typedef struct packed {
    load_t weight;
    press_t press;
  } curve_pt_s;

  // Three points per axle, ascending pressure
  typedef struct packed {
    curve_pt_s [2:0] pt;
  } curve_s;

  typedef struct packed {
    press_t [3:0] bar;
  } press_s;

  typedef struct packed {
    load_t [3:0] load;
  } load_report_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef enum logic {ST_IDLE, ST_RUN} ctl_state_e;

endpackage

//--- src/spc_load_conv.sv
// Piecewise-linear pressure to axle load conversion over a three-point curve.
// Assumes points are stored in ascending pressure; takes 30 cycles per start.
`timescale 1ns/10ps
`include "spc_regs.svh"

module spc_load_conv (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire spc_pkg::press_t press_i,
  input wire spc_pkg::curve_s curve_i,
  output spc_pkg::load_t load_o,
  output logic done_o
);
  import spc_pkg::*;

  // ----------------------------------------
  // Segment selection and clamping
  // ----------------------------------------
  wire logic seg_hi = press_i > curve_i.pt[1].press;
  wire press_t pa = seg_hi ? curve_i.pt[1].press : curve_i.pt[0].press;
  wire press_t pb = seg_hi ? curve_i.pt[2].press : curve_i.pt[1].press;
  wire load_t wa = seg_hi ? curve_i.pt[1].weight : curve_i.pt[0].weight;
  wire load_t wb = seg_hi ? curve_i.pt[2].weight : curve_i.pt[1].weight;
  // Clamp outside the curve so extrapolation never goes wild
  wire press_t pc = (press_i < pa) ? pa : ((press_i > pb) ? pb : press_i);
  wire logic falling = wb < wa;
  wire load_t dw = falling ? load_t'(wa - wb) : load_t'(wb - wa);
  wire logic [27:0] num = 28'(pc - pa) * 28'(dw);
  wire press_t den = press_t'(pb - pa);

  logic [12:0] rem_reg;
  logic [27:0] quo_reg;
  press_t den_reg;
  load_t base_reg;
  load_t lo_reg;
  load_t hi_reg;
  logic neg_reg;
  logic [4:0] cnt_reg;
  logic busy_reg;

  // One restoring division step per cycle
  wire logic [12:0] trial = {rem_reg[11:0], quo_reg[27]};
  wire logic fits = trial >= {1'b0, den_reg};
  wire logic [27:0] q_fin = quo_reg;

  // ----------------------------------------
  // Divider sequence
  // ----------------------------------------
  // segment interpolation
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rem_reg <= 13'h0000;
      quo_reg <= 28'h0000000;
      den_reg <= 12'h000;
      base_reg <= 16'h0000;
      lo_reg <= 16'h0000;
      hi_reg <= 16'h0000;
      neg_reg <= 1'b0;
      cnt_reg <= 5'h00;
      busy_reg <= 1'b0;
      done_o <= 1'b0;
      load_o <= 16'h0000;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        rem_reg <= 13'h0000;
        quo_reg <= (den == 12'h000) ? 28'h0000000 : num; // Flat segment gives base weight
        den_reg <= (den == 12'h000) ? 12'h001 : den;
        base_reg <= wa;
        lo_reg <= falling ? wb : wa;
        hi_reg <= falling ? wa : wb;
        neg_reg <= falling;
        cnt_reg <= 5'(`SPC_DIV_STEPS);
        busy_reg <= 1'b1;
      end else if (busy_reg && cnt_reg != 5'h00) begin
        rem_reg <= fits ? 13'(trial - {1'b0, den_reg}) : trial;
        quo_reg <= {quo_reg[26:0], fits};
        cnt_reg <= cnt_reg - 5'h01;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        done_o <= 1'b1;
        load_o <= neg_reg ? load_t'(base_reg - q_fin[15:0]) : load_t'(base_reg + q_fin[15:0]);
      end
    end
  end

  a_load_in_segment: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    done_o |-> (load_o >= lo_reg) && (load_o <= hi_reg))
    else $error("converted load outside its curve segment");

endmodule

//--- src/spc_ctrl.sv
// Solenoid pulse controller: proportional-rate pulse length per repetition
// period, valve drive, and averaged axle load reporting.
// Assumes level and pressure inputs synchronous to clk_sys_i; the load report
// is handed to a bus message formatter outside this block.
//
// What this block does
// - Fixed repetition period; each period with a positive length opens with an actuating pulse.
// - Pulse length is recomputed at the start of every period.
// - Control deviation is desired level minus measured level.
// - Length is |deviation x Kp| minus |deviation rate x Kd|.
// - Faster-changing deviation shortens the pulse to brake air inflow.
// - Length beyond the period keeps the valve energised the whole period.
// - Valve drive is strictly open or blocked, throttled by interruption.
// - Pulsing stops once the level sits inside the tolerance band.
// - Four axle curves, three weight/pressure points each, convert pressure to load.
// - Averaged axle loads are published every 100 ms.
// - No nonzero pulse shorter than 75 ms is ever issued.
`timescale 1ns/10ps
`include "spc_regs.svh"

module spc_ctrl #(
  parameter int MS_CYCLES = `SPC_MS_CYCLES,
  parameter int SAMPLE_CYCLES = `SPC_SAMPLE_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire spc_pkg::reg_req_s reg_req_i,
  output logic [15:0] reg_rdata_o,
  input wire spc_pkg::level_t actual_level_i,
  input wire spc_pkg::press_s pressure_i,
  output logic valve_raise_o,
  output logic valve_lower_o,
  output spc_pkg::load_report_s load_report_o,
  output logic load_report_valid_o
);
  import spc_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic enable_reg;
  logic [15:0] period_reg;
  logic [15:0] tol_reg;
  logic [7:0] kp_reg;
  logic [7:0] kd_reg;
  level_t desired_reg;
  logic [15:0] curve_reg [0:`SPC_CURVE_WORDS-1];

  wire logic [7:0] addr = reg_req_i.addr;
  wire logic [15:0] wdata = reg_req_i.wdata;
  wire logic wr_en = reg_req_i.wr && ce_i;
  wire logic rd_en = reg_req_i.rd && ce_i;
  wire logic [7:0] curve_idx = 8'(addr - `SPC_OFS_CURVE0);
  wire logic hit_curve = (addr >= `SPC_OFS_CURVE0) && (curve_idx < 8'(`SPC_CURVE_WORDS));
  wire logic hit_load = (addr >= `SPC_OFS_LOAD0) && (addr < 8'(`SPC_OFS_LOAD0 + 4));
  // A period shorter than the minimum pulse could cut a pulse short
  wire logic [15:0] period_wr = (wdata < 16'(`SPC_MIN_PULSE_MS)) ? 16'(`SPC_MIN_PULSE_MS) : wdata;

  // Configuration writes
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      enable_reg <= 1'b0;
      period_reg <= `SPC_RST_PERIOD;
      tol_reg <= `SPC_RST_TOL;
      kp_reg <= 8'(`SPC_RST_KP);
      kd_reg <= 8'(`SPC_RST_KD);
      desired_reg <= 12'(`SPC_RST_DESIRED);
    end else if (wr_en) begin
      if (addr == `SPC_OFS_CTRL) enable_reg <= wdata[`SPC_CTRL_EN_BIT];
      if (addr == `SPC_OFS_PERIOD) period_reg <= period_wr;
      if (addr == `SPC_OFS_TOL) tol_reg <= wdata;
      if (addr == `SPC_OFS_KP) kp_reg <= wdata[7:0];
      if (addr == `SPC_OFS_KD) kd_reg <= wdata[7:0];
      if (addr == `SPC_OFS_DESIRED) desired_reg <= wdata[11:0];
    end
  end

  // Calibration store; cleared at reset so conversions that run before the
  // first load see a flat zero curve instead of unknown words
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int i = 0; i < `SPC_CURVE_WORDS; i++) begin
        curve_reg[i] <= 16'h0000;
      end
    end else if (wr_en && hit_curve) begin
      curve_reg[curve_idx[4:0]] <= wdata;
    end
  end

  // ----------------------------------------
  // Millisecond time base
  // ----------------------------------------
  logic [31:0] ms_div_reg;
  wire logic ms_tick = ce_i && (ms_div_reg == 32'(MS_CYCLES - 1));

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ms_div_reg <= 32'h00000000;
    end else if (ce_i) begin
      ms_div_reg <= ms_tick ? 32'h00000000 : ms_div_reg + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Pulse length computation
  // ----------------------------------------
  ctl_state_e state_reg;
  logic [15:0] pcnt_reg;
  logic [15:0] len_reg;
  logic cont_reg;
  logic signed [12:0] dev_prev_reg;

  wire logic signed [12:0] dev = $signed({1'b0, desired_reg}) - $signed({1'b0, actual_level_i});
  wire logic [12:0] dev_abs = dev[12] ? 13'(-dev) : dev;
  wire logic signed [13:0] rate = 14'(dev) - 14'(dev_prev_reg);
  wire logic [13:0] rate_abs = rate[13] ? 14'(-rate) : rate;
  wire logic in_band = 16'(dev_abs) <= tol_reg;
  wire logic [22:0] p_term = 23'(dev_abs) * 23'(kp_reg);
  wire logic [22:0] d_term = 23'(rate_abs) * 23'(kd_reg);
  wire logic signed [23:0] raw_len = $signed({1'b0, p_term}) - $signed({1'b0, d_term});
  wire logic len_zero = raw_len <= 24'sh000000;
  wire logic [23:0] len_min = (raw_len < 24'(`SPC_MIN_PULSE_MS)) ? 24'(`SPC_MIN_PULSE_MS) : 24'(raw_len);
  wire logic len_cont = !len_zero && (len_min >= 24'(period_reg));
  wire logic [15:0] len_eff = len_zero ? 16'h0000 : (len_cont ? period_reg : len_min[15:0]);
  // a period starts at its end or while idle
  wire logic period_end = (state_reg == ST_IDLE) || (pcnt_reg == 16'(period_reg - 16'h0001));
  wire logic start_evt = ms_tick && period_end;
  wire logic go = enable_reg && !in_band;

  // Period sequencing and valve drive; stopping is only decided at a period
  // boundary so a pulse already issued is never cut below its length
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      pcnt_reg <= 16'h0000;
      len_reg <= 16'h0000;
      cont_reg <= 1'b0;
      dev_prev_reg <= 13'sh0000;
      valve_raise_o <= 1'b0;
      valve_lower_o <= 1'b0;
    end else if (start_evt) begin
      dev_prev_reg <= dev;
      pcnt_reg <= 16'h0000;
      case (state_reg)
        ST_IDLE, ST_RUN: begin
          state_reg <= go ? ST_RUN : ST_IDLE;
          len_reg <= go ? len_eff : 16'h0000;
          cont_reg <= go && len_cont;
          valve_raise_o <= go && !len_zero && !dev[12];
          valve_lower_o <= go && !len_zero && dev[12];
        end
        default: state_reg <= ST_IDLE;
      endcase
    end else if (ms_tick && state_reg == ST_RUN) begin
      pcnt_reg <= pcnt_reg + 16'h0001;
      if (!cont_reg && (16'(pcnt_reg + 16'h0001) == len_reg)) begin
        valve_raise_o <= 1'b0;
        valve_lower_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Axle load sampling and averaging
  // ----------------------------------------
  logic [31:0] samp_div_reg;
  logic [`SPC_AVG_SHIFT-1:0] samp_cnt_reg;
  logic conv_start_reg;
  wire logic samp_tick = ce_i && (samp_div_reg == 32'(SAMPLE_CYCLES - 1));
  wire logic [3:0] conv_done;
  load_t conv_load [0:3];
  logic [22:0] sum_reg [0:3];
  // Last sample of the interval closes the 100 ms report
  wire logic last_samp = conv_done[0] && (samp_cnt_reg == {`SPC_AVG_SHIFT{1'b1}});

  // Sample pacing: 128 samples per report interval keeps the mean a shift
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      samp_div_reg <= 32'h00000000;
      samp_cnt_reg <= '0;
      conv_start_reg <= 1'b0;
    end else if (ce_i) begin
      samp_div_reg <= samp_tick ? 32'h00000000 : samp_div_reg + 32'h00000001;
      conv_start_reg <= samp_tick;
      if (conv_done[0]) samp_cnt_reg <= samp_cnt_reg + 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_axle
      curve_s curve_w;
      always_comb begin
        for (int k = 0; k < 3; k++) begin
          curve_w.pt[k].weight = curve_reg[g * 6 + k * 2];
          curve_w.pt[k].press = curve_reg[g * 6 + k * 2 + 1][11:0];
        end
      end

      spc_load_conv u_conv (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .start_i(conv_start_reg),
        .press_i(pressure_i.bar[g]),
        .curve_i(curve_w),
        .load_o(conv_load[g]),
        .done_o(conv_done[g])
      );

      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          sum_reg[g] <= 23'h000000;
          load_report_o.load[g] <= 16'h0000;
        end else if (ce_i && conv_done[g]) begin
          if (last_samp) begin
            sum_reg[g] <= 23'h000000;
            load_report_o.load[g] <= 16'((sum_reg[g] + 23'(conv_load[g])) >> `SPC_AVG_SHIFT);
          end else begin
            sum_reg[g] <= 23'(sum_reg[g] + 23'(conv_load[g]));
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      load_report_valid_o <= 1'b0;
    end else if (ce_i) begin
      load_report_valid_o <= last_samp;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire logic [15:0] status_w = 16'({in_band, valve_lower_o, valve_raise_o, cont_reg, state_reg == ST_RUN});
  wire logic [15:0] rd_mux =
    (addr == `SPC_OFS_CTRL) ? {15'h0000, enable_reg} :
    (addr == `SPC_OFS_STATUS) ? status_w :
    (addr == `SPC_OFS_PERIOD) ? period_reg :
    (addr == `SPC_OFS_TOL) ? tol_reg :
    (addr == `SPC_OFS_KP) ? {8'h00, kp_reg} :
    (addr == `SPC_OFS_KD) ? {8'h00, kd_reg} :
    (addr == `SPC_OFS_DESIRED) ? {4'h0, desired_reg} :
    (addr == `SPC_OFS_PULSE) ? len_reg :
    hit_load ? load_report_o.load[addr[1:0]] :
    hit_curve ? curve_reg[curve_idx[4:0]] : 16'h0000;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (ce_i) begin
      reg_rdata_o <= rd_en ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [15:0] on_ms_reg;
  wire logic valve_on = valve_raise_o || valve_lower_o;

  // Milliseconds of the current energised stretch
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      on_ms_reg <= 16'h0000;
    end else if (ms_tick) begin
      on_ms_reg <= valve_on ? 16'(on_ms_reg + 16'h0001) : 16'h0000;
    end
  end

  a_valve_two_state: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !(valve_raise_o && valve_lower_o))
    else $error("valve driven both ways");

  a_pulse_min_length: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(valve_on) |-> $past(on_ms_reg) >= 16'(`SPC_MIN_PULSE_MS - 1))
    else $error("valve pulse shorter than minimum");

  a_period_start: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(valve_on) |-> $past(start_evt) && pcnt_reg == 16'h0000)
    else $error("pulse began away from period start");

  a_len_recompute: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (start_evt && go) |=> len_reg == $past(len_eff))
    else $error("pulse length not refreshed at period start");

  a_pd_equation: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (start_evt && go && !len_zero && !len_cont && raw_len > 24'sd75)
      |=> 24'(len_reg) == $past(24'(p_term) - 24'(d_term)))
    else $error("pulse length differs from proportional-rate result");

  a_dev_direction: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (start_evt && go && !len_zero) |=> (valve_raise_o == !$past(dev[12])))
    else $error("valve direction disagrees with deviation sign");

  a_continuous_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (cont_reg && valve_on && ms_tick && !period_end) |=> valve_on)
    else $error("continuous pulse interrupted mid-period");

  a_zero_len_off: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (start_evt && len_zero) |=> !valve_on [*2])
    else $error("valve energised with nonpositive length");

  a_band_stop: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (start_evt && in_band) |=> state_reg == ST_IDLE && !valve_on)
    else $error("regulation continued inside tolerance band");

  a_report_pulse: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    load_report_valid_o |-> $past(conv_done[0]) && $past(samp_cnt_reg) == {`SPC_AVG_SHIFT{1'b1}} ##1 !load_report_valid_o)
    else $error("load report not at end of averaging interval");

  a_rate_shortens: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (start_evt && go && !len_cont && d_term != 23'h000000 && raw_len >= 24'sd75)
      |=> 24'(len_reg) < $past(24'(p_term)))
    else $error("rate term failed to shorten the pulse");

  a_idle_valve_off: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_reg == ST_IDLE |-> !valve_on)
    else $error("valve energised while regulation is idle");

  c_continuous: cover property (@(posedge clk_sys_i) disable iff (srst_i) start_evt && go && len_cont);
  c_lowering: cover property (@(posedge clk_sys_i) disable iff (srst_i) $rose(valve_lower_o));
  c_stretched: cover property (@(posedge clk_sys_i) disable iff (srst_i) start_evt && go && !len_zero && raw_len < 24'sd75);
  c_band_reached: cover property (@(posedge clk_sys_i) disable iff (srst_i) state_reg == ST_RUN ##1 state_reg == ST_IDLE);
  c_report: cover property (@(posedge clk_sys_i) disable iff (srst_i) load_report_valid_o);

endmodule

//--- tb/spc_valve_bus_model.sv
// Far side of the controller: valve actuator timing monitor and load report sink.
// Assumes registered valve drives and report outputs on clk_sys_i.
`timescale 1ns/10ps

module spc_valve_bus_model (
  input wire logic clk_sys_i,
  input wire logic valve_raise_i,
  input wire logic valve_lower_i,
  input wire spc_pkg::load_report_s report_i,
  input wire logic report_valid_i,
  output spc_pkg::press_s pressure_o,
  output spc_pkg::load_report_s last_rep_o,
  output int on_cyc_o,
  output int iv_cyc_o,
  output int rises_o,
  output int reports_o,
  output int rep_gap_o,
  output logic both_on_o
);
  import spc_pkg::*;
  int cyc = 0;
  int rise_t = 0;
  int rep_t = 0;
  logic on_d = 1'b0;
  wire logic on_w = valve_raise_i | valve_lower_i;

  // Steady pressures keep every mean exact; axles 0 and 2 sit on the upper
  // segment, axle 1 on the lower one, axle 3 above the top point so it clamps
  assign pressure_o = 48'hC00600200500;

  // Measure energised runs and the spacing of actuating pulses
  initial begin
    {on_cyc_o, iv_cyc_o, rises_o, reports_o, rep_gap_o} <= '0;
    both_on_o <= 1'b0;
    last_rep_o <= '0;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    on_d <= on_w;
    if (valve_raise_i === 1'b1 && valve_lower_i === 1'b1) begin
      both_on_o <= 1'b1;
    end
    if (on_w === 1'b1 && on_d === 1'b0) begin
      iv_cyc_o <= cyc - rise_t;
      rise_t <= cyc;
      rises_o <= rises_o + 1;
    end
    if (on_w === 1'b0 && on_d === 1'b1) begin
      on_cyc_o <= cyc - rise_t;
    end
    // Bus side: take each published load set and its interval
    if (report_valid_i === 1'b1) begin
      last_rep_o <= report_i;
      rep_gap_o <= cyc - rep_t;
      rep_t <= cyc;
      reports_o <= reports_o + 1;
    end
  end
endmodule

//--- tb/solenoid_pulse_pd_controller_tb.sv
// Self-checking bench for the solenoid pulse controller.
// Assumes the word-indexed register port and shortened ms/sample counts.
`timescale 1ns/10ps
`include "spc_regs.svh"

module solenoid_pulse_pd_controller_tb;
  import spc_pkg::*;
  localparam int MSC = 20;
  localparam int SC = 40;
  localparam int PER = 100;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  reg_req_s req = '0;
  level_t lvl = 12'h7A6;
  logic [15:0] rdata;
  logic [15:0] d;
  logic raise, lower, rep_valid, both_on;
  load_report_s rep, last_rep;
  press_s press;
  int on_cyc, iv_cyc, rises, reports, rep_gap, r;
  int miscompares = 0;
  int checked = 0;
  logic [7:0] ra [7] = '{`SPC_OFS_CTRL, `SPC_OFS_PERIOD, `SPC_OFS_TOL, `SPC_OFS_KP, `SPC_OFS_KD,
                         `SPC_OFS_DESIRED, 8'h40};
  logic [15:0] rv [7] = '{16'h0000, `SPC_RST_PERIOD, `SPC_RST_TOL, `SPC_RST_KP, `SPC_RST_KD,
                          `SPC_RST_DESIRED, 16'h0000};
  logic [15:0] ld [4] = '{16'h0500, 16'h0400, 16'h1200, 16'h2000};

  always #2.5 clk_sys_i = ~clk_sys_i;

  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  spc_ctrl #(.MS_CYCLES(MSC), .SAMPLE_CYCLES(SC)) dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .ce_i(ce_i), .reg_req_i(req), .reg_rdata_o(rdata), .actual_level_i(lvl), .pressure_i(press),
    .valve_raise_o(raise), .valve_lower_o(lower), .load_report_o(rep), .load_report_valid_o(rep_valid));
  spc_valve_bus_model far_u (.clk_sys_i(clk_sys_i), .valve_raise_i(raise), .valve_lower_i(lower),
    .report_i(rep), .report_valid_i(rep_valid), .pressure_o(press), .last_rep_o(last_rep),
    .on_cyc_o(on_cyc), .iv_cyc_o(iv_cyc), .rises_o(rises), .reports_o(reports), .rep_gap_o(rep_gap),
    .both_on_o(both_on));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] dt);
    @(posedge clk_sys_i);
    req <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    req <= '0;
  endtask

  // Data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] dv);
    @(posedge clk_sys_i);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    req <= '0;
    #1;
    dv = rdata;
  endtask

  // Bounded wait for a valve level; running out ends the run
  task automatic wait_v(input logic sel, input logic lv, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_sys_i);
      #1;
      if ((sel ? lower : raise) === lv) return;
    end
    miscompares++;
    finish_test();
  endtask

  task automatic rise_chk(input logic sel, input int iv_ms);
    wait_v(sel, 1'b1, 4200);
    @(posedge clk_sys_i);
    #1;
    if (iv_ms > 0) chk(iv_cyc, iv_ms * MSC);
  endtask

  task automatic fall_chk(input logic sel, input int on_ms, input level_t nxt);
    wait_v(sel, 1'b0, 4200);
    @(posedge clk_sys_i);
    lvl <= nxt;
    #1;
    chk(on_cyc, on_ms * MSC);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], d);
      chk(d, rv[i]);
    end
    @(posedge clk_sys_i);
    #1;
    chk(rdata, 16'h0000);
    wr(`SPC_OFS_PERIOD, 16'h000A);
    rd(`SPC_OFS_PERIOD, d);
    chk(d, 16'h004B);
    wr(`SPC_OFS_PERIOD, 16'(PER));
    wr(`SPC_OFS_KP, 16'h0001);
    // Linear curves: load is pressure times axle number plus one
    for (int a = 0; a < 4; a++) begin
      for (int k = 0; k < 3; k++) begin
        wr(8'(32 + 6 * a + 2 * k), 16'(k * 1024 * (a + 1)));
        wr(8'(33 + 6 * a + 2 * k), 16'(k * 1024));
      end
    end
    wr(`SPC_OFS_CTRL, 16'h0001);
    // Raise 90 ms, then rate-shortened, skipped and stretched periods
    rise_chk(1'b0, 0);
    rd(`SPC_OFS_PULSE, d);
    chk(d, 16'h005A);
    rd(`SPC_OFS_STATUS, d);
    chk(d[`SPC_ST_RAISE_BIT], 1'b1);
    fall_chk(1'b0, 90, 12'h7B0);
    rise_chk(1'b0, PER);
    fall_chk(1'b0, 75, 12'h7CE);
    rise_chk(1'b0, 2 * PER);
    fall_chk(1'b0, 75, 12'h85A);
    wr(`SPC_OFS_KP, 16'h0004);
    // Lowering: 360 - 280 ms, then beyond the period
    rise_chk(1'b1, PER);
    fall_chk(1'b1, 80, 12'h85A);
    rise_chk(1'b1, PER);
    r = rises;
    repeat (2 * PER * MSC + 100) @(posedge clk_sys_i);
    #1;
    chk(lower, 1'b1);
    chk(rises, r);
    rd(`SPC_OFS_STATUS, d);
    chk(d[`SPC_ST_CONT_BIT], 1'b1);
    // Level into the band: pulsing stops for good
    @(posedge clk_sys_i);
    lvl <= 12'h804;
    wait_v(1'b1, 1'b0, 2100);
    r = rises;
    repeat (2 * PER * MSC + 100) @(posedge clk_sys_i);
    #1;
    chk(rises, r);
    rd(`SPC_OFS_STATUS, d);
    chk({d[`SPC_ST_BAND_BIT], d[`SPC_ST_RUN_BIT]}, 2'b10);
    // Two fresh reports of averaged axle loads
    r = reports;
    for (int i = 0; i < 12000 && reports < r + 2; i++) @(posedge clk_sys_i);
    #1;
    chk(reports, r + 2);
    chk(rep_gap, 128 * SC);
    for (int a = 0; a < 4; a++) begin
      chk(last_rep.load[a], ld[a]);
      rd(8'(`SPC_OFS_LOAD0 + a), d);
      chk(d, ld[a]);
    end
    chk(both_on, 1'b0);
    finish_test();
  end
endmodule
